// [rtl/lla_pkg.sv]
// Constants, types and timing for the liquid level alarm sequencer
// What this block does
// RULE_01: Excitation wave is oscillator divided by 32
// RULE_02: Excitation wave has equal high and low
// RULE_03: One sensor sample per period, positive half
// RULE_04: Comparator result ignored while excitation low
// RULE_05: Alarm condition needs four consecutive alarm samples
// RULE_06: Activation delay 16384 or 32768 oscillator periods
// RULE_07: Condition lost during delay abandons activation
// RULE_08: Activated alarm stays latched until power off
// RULE_09: Undervoltage reset clears all state and latch
// RULE_10: Alarm output period is 512 oscillator periods
// RULE_11: On-time half period or one sixty-fourth
// RULE_12: Polarity select chooses above or below alarm
// RULE_13: Comparator result holds between the two thresholds
// RULE_14: Delay count restarts from zero each time
package lla_pkg;

  // ==========================================================
  // Clock and oscillator
  localparam int SYS_CLK_HZ     = 250_000_000;
  localparam int OSC_HZ         = 1600;
  localparam int OSC_DIV_CYCLES = SYS_CLK_HZ / OSC_HZ;

  // ==========================================================
  // Excitation and sampling
  localparam int EXC_DIVIDE      = 32;
  localparam int EXC_W           = $clog2(EXC_DIVIDE);
  localparam int EXC_HALF        = EXC_DIVIDE / 2;
  localparam logic [4:0] EXC_SAMPLE_POS = 5'(EXC_HALF - 1);
  localparam int CONFIRM_SAMPLES = 4;
  localparam int CONF_W          = 3;
  localparam logic [2:0] CONF_FULL = 3'(CONFIRM_SAMPLES);

  // ==========================================================
  // Activation delay, times in ms at the nominal oscillator
  localparam int DELAY_SHORT_MS    = 10240;
  localparam int DELAY_LONG_MS     = 20480;
  localparam int DELAY_SHORT_TICKS = DELAY_SHORT_MS * OSC_HZ / 1000;
  localparam int DELAY_LONG_TICKS  = DELAY_LONG_MS * OSC_HZ / 1000;
  localparam int DELAY_W           = 16;
  localparam logic [15:0] DELAY_SHORT_LAST = 16'(DELAY_SHORT_TICKS - 1);
  localparam logic [15:0] DELAY_LONG_LAST  = 16'(DELAY_LONG_TICKS - 1);

  // ==========================================================
  // Alarm output waveform
  localparam int OUT_PERIOD_MS    = 320;
  localparam int OUT_ON_SHORT_MS  = 5;
  localparam int OUT_PERIOD_TICKS = OUT_PERIOD_MS * OSC_HZ / 1000;
  localparam int OUT_W            = $clog2(OUT_PERIOD_TICKS);
  localparam logic [8:0] OUT_LAST     = 9'(OUT_PERIOD_TICKS - 1);
  localparam logic [8:0] OUT_ON_HALF  = 9'(OUT_PERIOD_TICKS / 2);
  localparam logic [8:0] OUT_ON_SHORT = 9'(OUT_ON_SHORT_MS * OSC_HZ / 1000);

  // ==========================================================
  // Reset values
  localparam logic [4:0]  RST_EXC   = 5'h00;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [8:0]  RST_OUT   = 9'h000;
  localparam logic [2:0]  RST_CONF  = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_ACTIVE
  } seq_state_t;

endpackage

// [rtl/sensor_qualifier.sv]
// Sensor hysteresis, polarity and consecutive-sample confirmation
`timescale 1ns/1ps
module sensor_qualifier (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic excitation_high,
  input  wire logic sample_strobe,
  input  wire logic sense_above_high,
  input  wire logic sense_below_low,
  input  wire logic polarity_duty_select_input,
  output logic      alarm_condition
);

  logic       above;
  logic       next_above;
  logic [2:0] run_count;
  logic [2:0] next_run_count;
  logic       indication;

  // ==========================================================
  // Hysteresis and polarity
  // Comparator is only looked at during the positive half
  always_comb begin
    next_above = above;
    if (excitation_high) begin // RULE_04
      if (sense_above_high) begin
        next_above = 1'b1;
      end else if (sense_below_low) begin // RULE_13
        next_above = 1'b0;
      end
    end
  end

  assign indication = polarity_duty_select_input ? ~above : above; // RULE_12

  // ==========================================================
  // Consecutive sample run
  always_comb begin
    next_run_count = run_count;
    if (sample_strobe) begin
      if (!indication) begin
        next_run_count = lla_pkg::RST_CONF; // RULE_05
      end else if (run_count != lla_pkg::CONF_FULL) begin
        next_run_count = run_count + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin // RULE_09
      above     <= 1'b0;
      run_count <= lla_pkg::RST_CONF;
    end else begin
      above     <= next_above;
      run_count <= next_run_count;
    end
  end

  assign alarm_condition = (run_count == lla_pkg::CONF_FULL);

  AST_IGNORE_LOW: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_04
    !excitation_high |=> $stable(above))
    else $error("comparator state moved while excitation low");

  AST_HYST_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_13
    excitation_high && !sense_above_high && !sense_below_low |=> $stable(above))
    else $error("comparator state moved between thresholds");

  AST_CONFIRM_FOUR: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_05
    $rose(alarm_condition) |-> $past(run_count) == 3'h3 && $past(sample_strobe))
    else $error("alarm condition without four samples");

  AST_BREAK_RUN: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_12
    sample_strobe && (polarity_duty_select_input == above) |=> run_count == 3'h0)
    else $error("non-alarm sample did not break the run");

endmodule

// [rtl/liquid_level_alarm_sequencer.sv]
// Liquid level alarm sequencer: excitation, delay, latch and output pulse
`timescale 1ns/1ps
module liquid_level_alarm_sequencer #(
  parameter int OSC_DIV = lla_pkg::OSC_DIV_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic delay_select_input,
  input  wire logic polarity_duty_select_input,
  input  wire logic sense_above_high,
  input  wire logic sense_below_low,
  output logic      sensor_excitation_output,
  output logic      alarm_drive,
  output logic      alarm_condition,
  output logic      alarm_latched
);

  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  logic [DIV_W-1:0]  div_cnt;
  logic [DIV_W-1:0]  next_div_cnt;
  logic              osc_tick;
  logic [4:0]        exc_cnt;
  logic [4:0]        next_exc_cnt;
  logic              next_excitation;
  logic              sample_strobe;
  lla_pkg::seq_state_t state;
  lla_pkg::seq_state_t next_state;
  logic [15:0]       delay_cnt;
  logic [15:0]       next_delay_cnt;
  logic [15:0]       delay_last;
  logic [8:0]        out_phase;
  logic [8:0]        next_out_phase;
  logic [8:0]        on_ticks;
  logic              next_alarm_drive;

  // ==========================================================
  // Oscillator tick
  // The internal oscillator is modelled as a tick from the system clock;
  // shorten OSC_DIV in simulation, the real count is far too long.
  always_comb begin
    osc_tick     = (div_cnt == DIV_LAST);
    next_div_cnt = osc_tick ? DIV_ZERO : div_cnt + DIV_W'(1);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin // RULE_09
      div_cnt <= DIV_ZERO;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ==========================================================
  // Sensor excitation
  // High for the first half of the 32-tick count, low for the second
  always_comb begin
    next_exc_cnt = exc_cnt;
    if (osc_tick) begin
      next_exc_cnt = exc_cnt + 5'h01; // RULE_01
    end
    next_excitation = ~next_exc_cnt[4]; // RULE_02
  end

  // Last tick of the positive half: the comparator has settled all half
  assign sample_strobe = osc_tick && (exc_cnt == lla_pkg::EXC_SAMPLE_POS); // RULE_03

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      exc_cnt                  <= lla_pkg::RST_EXC;
      sensor_excitation_output <= 1'b1;
    end else begin
      exc_cnt                  <= next_exc_cnt;
      sensor_excitation_output <= next_excitation;
    end
  end

  // ==========================================================
  // Sample qualification
  sensor_qualifier u_qualifier (
    .sys_clk                    (sys_clk),
    .rstn                       (rstn),
    .excitation_high            (sensor_excitation_output),
    .sample_strobe              (sample_strobe),
    .sense_above_high           (sense_above_high),
    .sense_below_low            (sense_below_low),
    .polarity_duty_select_input (polarity_duty_select_input),
    .alarm_condition            (alarm_condition)
  );

  // ==========================================================
  // Activation delay and latch
  // The delay pin is read live, so changing it mid-delay moves the target.
  assign delay_last = delay_select_input ? lla_pkg::DELAY_LONG_LAST
                                         : lla_pkg::DELAY_SHORT_LAST; // RULE_06

  always_comb begin
    next_state     = state;
    next_delay_cnt = delay_cnt;
    case (state)
      lla_pkg::ST_IDLE: begin
        next_delay_cnt = lla_pkg::RST_DELAY; // RULE_14
        if (alarm_condition) begin
          next_state = lla_pkg::ST_DELAY;
        end
      end
      lla_pkg::ST_DELAY: begin
        if (!alarm_condition) begin
          next_state     = lla_pkg::ST_IDLE; // RULE_07
          next_delay_cnt = lla_pkg::RST_DELAY;
        end else if (osc_tick) begin
          if (delay_cnt >= delay_last) begin
            next_state = lla_pkg::ST_ACTIVE; // RULE_06
          end else begin
            next_delay_cnt = delay_cnt + 16'h0001;
          end
        end
      end
      lla_pkg::ST_ACTIVE: begin
        // Sensor is no longer consulted: a broken lead cannot silence it
        next_state = lla_pkg::ST_ACTIVE; // RULE_08
      end
      default: begin
        next_state     = lla_pkg::ST_IDLE;
        next_delay_cnt = lla_pkg::RST_DELAY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin // RULE_09
      state     <= lla_pkg::ST_IDLE;
      delay_cnt <= lla_pkg::RST_DELAY;
    end else begin
      state     <= next_state;
      delay_cnt <= next_delay_cnt;
    end
  end

  assign alarm_latched = (state == lla_pkg::ST_ACTIVE);

  // ==========================================================
  // Alarm output waveform
  assign on_ticks = polarity_duty_select_input ? lla_pkg::OUT_ON_HALF
                                               : lla_pkg::OUT_ON_SHORT; // RULE_11

  always_comb begin
    next_out_phase = out_phase;
    if (state != lla_pkg::ST_ACTIVE) begin
      next_out_phase = lla_pkg::RST_OUT;
    end else if (osc_tick) begin
      if (out_phase == lla_pkg::OUT_LAST) begin
        next_out_phase = lla_pkg::RST_OUT; // RULE_10
      end else begin
        next_out_phase = out_phase + 9'h001;
      end
    end
    next_alarm_drive = (next_state == lla_pkg::ST_ACTIVE) &&
                       (next_out_phase < on_ticks); // RULE_11
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_phase   <= lla_pkg::RST_OUT;
      alarm_drive <= 1'b0;
    end else begin
      out_phase   <= next_out_phase;
      alarm_drive <= next_alarm_drive;
    end
  end

  // ==========================================================
  // Checks
  AST_EXC_WRAP: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_01
    $rose(sensor_excitation_output) |-> exc_cnt == 5'h00 && $past(exc_cnt) == 5'h1f)
    else $error("excitation rose away from the count wrap");

  AST_EXC_STEP: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_01
    !osc_tick |=> $stable(exc_cnt))
    else $error("excitation count moved between ticks");

  AST_EXC_HALF: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_02
    sensor_excitation_output == (exc_cnt < 5'h10))
    else $error("excitation level does not match its half");

  AST_SAMPLE_POS: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_03
    sample_strobe |-> sensor_excitation_output ##1 !sensor_excitation_output)
    else $error("sample not at end of positive half");

  AST_DELAY_RESTART: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_14
    $rose(state == lla_pkg::ST_DELAY) |-> delay_cnt == 16'h0000)
    else $error("delay count did not start from zero");

  AST_DELAY_EXPIRE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_06
    $rose(state == lla_pkg::ST_ACTIVE) |->
      $past(delay_cnt) == ($past(delay_select_input) ? 16'h7fff : 16'h3fff))
    else $error("activation before the selected delay");

  AST_ABANDON: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_07
    state == lla_pkg::ST_DELAY && !alarm_condition |=>
      state == lla_pkg::ST_IDLE && !alarm_drive)
    else $error("pending activation not abandoned");

  AST_LATCH: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_08
    state == lla_pkg::ST_ACTIVE |=> state == lla_pkg::ST_ACTIVE)
    else $error("alarm latch released");

  AST_PERIOD: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_10
    state == lla_pkg::ST_ACTIVE && osc_tick && out_phase == 9'h1ff |=>
      out_phase == 9'h000 && alarm_drive)
    else $error("output period not 512 ticks");

  AST_PHASE_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_10
    state != lla_pkg::ST_ACTIVE |-> out_phase == 9'h000)
    else $error("output phase running outside activation");

  // Drive is registered, so it follows the duty pin as it stood one edge earlier
  AST_ON_TIME: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_11
    alarm_drive == (state == lla_pkg::ST_ACTIVE &&
      out_phase < ($past(polarity_duty_select_input) ? 9'h100 : 9'h008)))
    else $error("alarm on-time wrong for duty select");

  AST_NO_DRIVE_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_07
    state != lla_pkg::ST_ACTIVE |-> !alarm_drive)
    else $error("alarm driven before activation");

endmodule

// [verif/level_sensor_model.sv]
// Sensor and comparator model seen by the sequencer
`timescale 1ns/1ps
module level_sensor_model (
  input  wire logic       sys_clk,
  input  wire logic       sensor_excitation_output,
  input  wire logic [1:0] level,
  output logic            sense_above_high,
  output logic            sense_below_low
);
  // ==========================================================
  // Comparator outputs
  logic [1:0] junk = 2'h0;

  // The sense line is not driven in the low half, so its comparator sees garbage
  always @(posedge sys_clk) begin
    junk <= 2'($urandom);
  end

  // Level 2 is above the high threshold, 0 below the low one, 1 between the two
  always_comb begin
    if (sensor_excitation_output) begin
      sense_above_high = (level == 2'h2);
      sense_below_low  = (level == 2'h0);
    end else begin
      sense_above_high = junk[0];
      sense_below_low  = junk[1];
    end
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the liquid level alarm sequencer
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Signals
  localparam int DIV = 2;
  typedef struct {int sig; logic [15:0] exp;} note_t;
  logic        sys_clk;
  logic        rstn;
  logic        delay_select_input;
  logic        polarity_duty_select_input;
  logic [1:0]  level;
  logic        sense_above_high;
  logic        sense_below_low;
  logic        sensor_excitation_output;
  logic        alarm_drive;
  logic        alarm_condition;
  logic        alarm_latched;
  logic [15:0] meas;
  int          miscompares;
  int          num_checks;
  int          n;
  note_t       notes[$];
  note_t       nt;
  string       nm[5] = '{"excitation", "condition", "latched", "drive", "width"};

  `define CHK(name, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %0h seen %0h", name, e, g); end end

  liquid_level_alarm_sequencer #(.OSC_DIV(DIV)) dut (
    .sys_clk                    (sys_clk),
    .rstn                       (rstn),
    .delay_select_input         (delay_select_input),
    .polarity_duty_select_input (polarity_duty_select_input),
    .sense_above_high           (sense_above_high),
    .sense_below_low            (sense_below_low),
    .sensor_excitation_output   (sensor_excitation_output),
    .alarm_drive                (alarm_drive),
    .alarm_condition            (alarm_condition),
    .alarm_latched              (alarm_latched)
  );

  level_sensor_model sensor (
    .sys_clk                  (sys_clk),
    .sensor_excitation_output (sensor_excitation_output),
    .level                    (level),
    .sense_above_high         (sense_above_high),
    .sense_below_low          (sense_below_low)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic cur(int s);
    case (s)
      0: return sensor_excitation_output;
      1: return alarm_condition;
      2: return alarm_latched;
      default: return alarm_drive;
    endcase
  endfunction

  task automatic note(int s, logic [15:0] e);
    notes.push_back('{s, e});
  endtask

  task automatic wait_for(int s, logic v);
    int c;
    c = 0;
    do begin
      @(posedge sys_clk);
      #1;
      c++;
    end while (cur(s) !== v && c < 70000);
  endtask

  // Counts the cycles of the next full run of v
  task automatic width(int s, logic v);
    wait_for(s, !v);
    wait_for(s, v);
    n = 0;
    while (cur(s) === v && n < 4000) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    meas = 16'(n);
  endtask

  // Level set in the low half so the whole high half sees it
  task automatic smp(logic [1:0] l);
    wait_for(0, 1'b0);
    @(posedge sys_clk) level <= l;
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
  endtask

  task automatic end_sim();
    @(negedge sys_clk);
    #1;
    $display("Checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // Result watcher
  initial begin
    forever begin
      @(negedge sys_clk);
      while (notes.size() > 0) begin
        nt = notes.pop_front();
        if (nt.sig == 4) `CHK(nm[4], nt.exp, meas)
        else `CHK(nm[nt.sig], nt.exp, {15'h0, cur(nt.sig)})
      end
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(97517));
    rstn = 1'b0;
    delay_select_input = 1'b0;
    polarity_duty_select_input = 1'b0;
    level = 2'h1;
    meas = 16'h0000;
    miscompares = 0;
    num_checks = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    note(0, 16'h0001);
    note(3, 16'h0000);
    width(0, 1'b1);
    note(4, 16'(16 * DIV));
    width(0, 1'b0);
    note(4, 16'(16 * DIV));
    // A broken run of random length never confirms
    repeat (1 + $urandom % 3) smp(2'h2);
    smp(2'h0);
    note(1, 16'h0000);
    smp(2'h2);
    smp(2'h1);
    smp(2'h1);
    note(1, 16'h0000);
    smp(2'h1);
    note(1, 16'h0001);
    // Long partial delay, then abort; the next delay must start from zero
    repeat (6400) @(posedge sys_clk);
    smp(2'h0);
    note(1, 16'h0000);
    note(2, 16'h0000);
    note(3, 16'h0000);
    @(posedge sys_clk) polarity_duty_select_input <= 1'b1;
    repeat (3) smp(2'h0);
    note(1, 16'h0000);
    smp(2'h0);
    note(1, 16'h0001);
    n = 0;
    while (alarm_latched !== 1'b1 && n < 40000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    meas = 16'(n >= 16384 * DIV - 2 && n <= 16384 * DIV + 4);
    note(4, 16'h0001);
    note(3, 16'h0001);
    width(3, 1'b1);
    note(4, 16'(256 * DIV));
    width(3, 1'b0);
    note(4, 16'(256 * DIV));
    @(posedge sys_clk) polarity_duty_select_input <= 1'b0;
    @(posedge sys_clk) level <= 2'h0;
    width(3, 1'b1);
    note(4, 16'(8 * DIV));
    width(3, 1'b0);
    note(4, 16'(504 * DIV));
    note(2, 16'h0001);
    note(1, 16'h0000);
    @(posedge sys_clk) rstn <= 1'b0;
    #1;
    note(2, 16'h0000);
    note(3, 16'h0000);
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    delay_select_input <= 1'b1;
    repeat (4) smp(2'h2);
    note(1, 16'h0001);
    repeat (16384 * DIV + 40) @(posedge sys_clk);
    #1;
    note(2, 16'h0000);
    note(3, 16'h0000);
    end_sim();
  end
endmodule
